//--- spm_pkg.sv
// package: register map, field positions, reset values, timing counts
package spm_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] SPM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SPM_ADDR_CFG  = 8'h04;
  localparam logic [7:0] SPM_ADDR_DATA = 8'h08;
  localparam logic [7:0] SPM_ADDR_RATE = 8'h0C;

  // ****************************************************************
  // serial_control_reg fields
  // ****************************************************************
  localparam int SPM_CTL_DONE  = 7;
  localparam int SPM_CTL_WRITE_COLLISION_FLAG  = 6;
  localparam int SPM_CTL_MODE_FAULT_FLAG  = 5;
  localparam int SPM_CTL_OVRN  = 4;
  localparam int SPM_CTL_SELHI = 3;
  localparam int SPM_CTL_SELLO = 2;
  localparam int SPM_CTL_TXBMT = 1;
  localparam int SPM_CTL_EN    = 0;

  // ****************************************************************
  // serial_config_reg fields
  // ****************************************************************
  localparam int SPM_CFG_BUSY  = 7;
  localparam int SPM_CFG_MASTER_ENABLE_BIT = 6;
  localparam int SPM_CFG_PHA   = 5;
  localparam int SPM_CFG_POL   = 4;
  localparam int SPM_CFG_SLSEL = 3;
  localparam int SPM_CFG_NSSIN = 2;
  localparam int SPM_CFG_SRMT  = 1;
  localparam int SPM_CFG_RXBMT = 0;

  // ****************************************************************
  // reset values, modes, counts, responses
  // ****************************************************************
  localparam logic [7:0] SPM_CTRL_RST = 8'h06;
  localparam logic [7:0] SPM_CFG_RST  = 8'h07;
  localparam logic [7:0] SPM_RATE_RST = 8'h00;
  localparam logic [1:0] SPM_SEL_3WIRE = 2'h0;
  localparam logic [1:0] SPM_SEL_MULTI = 2'h1;
  localparam logic [2:0] SPM_LAST_BIT  = 3'h7;
  localparam logic [1:0] SPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPM_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    SPM_IDLE = 1'b0,
    SPM_RUN  = 1'b1
  } spm_state_e;

  // aligned word inside the four-register map
  function automatic logic spm_hit(input logic [7:0] a);
    spm_hit = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
  endfunction

endpackage

//--- spm_sync.sv
// two-flop synchroniser for pin inputs and the reset release
`timescale 1ns/1ps
module spm_sync
  import spm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

//--- spm_axil.sv
// axi4-lite slave front end: handshakes, responses, read data register
`timescale 1ns/1ps
module spm_axil
  import spm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic [7:0] rd_mux,
  output logic            wr_take,
  output logic            rd_take
);

  // ****************************************************************
  // write channel: address and data taken together
  // ****************************************************************
  logic wr_go;

  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_take       = wr_go & spm_hit(s_axi_awaddr) & s_axi_wstrb[0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SPM_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= spm_hit(s_axi_awaddr) ? SPM_RESP_OKAY
                                             : SPM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= SPM_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_mux};
      s_axi_rresp  <= spm_hit(s_axi_araddr) ? SPM_RESP_OKAY
                                             : SPM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- spm_top.sv
// serial port unit: master/slave spi with select modes and axi4-lite regs
// Overview of operation
// R01: master drives data-out from shift register msb, msb first always.
// R02: slave output pin floats when disabled or unselected four-wire slave.
// R03: three-wire slave always drives slave output from shift register msb.
// R04: clock driven only as master; four-wire slave ignores clock when select high.
// R05: select mode 00 is three-wire, pin unused, slave always selected.
// R06: mode 01 makes select an input; selects slave, faults master.
// R07: mode 1x drives select pin with lower mode bit; master use only.
// R08: select routed to a pin in every mode except three-wire.
// R09: master-enable bit 6 picks master, otherwise enabled unit is slave.
// R10: data write loads transmit buffer; empty shift register starts transfer.
// R11: master transfer shifts data out while clocking immediately.
// R12: transfer-done flag bit 7 set at every transfer end.
// R13: master shifts returned bits msb first, then copies byte to rx buffer.
// R14: after reset select mode is multi-master, bit 3 clear, bit 2 set.
// R15: low select in multi-master clears enables, sets mode fault flag.
// R16: three-wire master slaves are selected by outside general pins.
// R17: write while transmit buffer full sets collision flag and is dropped.
// R18: phase bit picks latching edge, polarity bit picks idle level.
// R19: clock rate register sets master bit rate, at most half system clock.
// R20: master counts exactly eight clocks, then reports shift register empty.
// R21: mode fault acts within few clocks and aborts transfer in progress.
`timescale 1ns/1ps
module spm_top
  import spm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  input  wire logic        nss_in,
  output logic             nss_out,
  output logic             nss_oe_n,
  output logic             nss_routed
);

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  logic [0:0] rst_q;
  logic       rst_n;
  logic [3:0] pins_s;
  logic       sck_s;
  logic       mosi_s;
  logic       miso_s;
  logic       nss_s;

  spm_sync #(.W(1)) u_rst (
    .clock   (clock),
    .reset_n (reset_n),
    .d       (1'b1),
    .q       (rst_q)
  );
  assign rst_n = rst_q[0];

  spm_sync #(.W(4)) u_pins (
    .clock   (clock),
    .reset_n (rst_n),
    .d       ({sck_in, mosi_in, miso_in, nss_in}),
    .q       (pins_s)
  );
  assign {sck_s, mosi_s, miso_s, nss_s} = pins_s;

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic       wr_take;
  logic       rd_take;
  logic [7:0] rd_mux;
  logic [7:0] wd;
  logic       wr_ctl;
  logic       wr_cfg;
  logic       wr_dat;
  logic       wr_rate;
  logic       rd_dat;

  spm_axil u_axil (
    .clock         (clock),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rd_mux        (rd_mux),
    .wr_take       (wr_take),
    .rd_take       (rd_take)
  );

  assign wd      = s_axi_wdata[7:0];
  assign wr_ctl  = wr_take & (s_axi_awaddr == SPM_ADDR_CTRL);
  assign wr_cfg  = wr_take & (s_axi_awaddr == SPM_ADDR_CFG);
  assign wr_dat  = wr_take & (s_axi_awaddr == SPM_ADDR_DATA);
  assign wr_rate = wr_take & (s_axi_awaddr == SPM_ADDR_RATE);
  assign rd_dat  = rd_take & (s_axi_araddr == SPM_ADDR_DATA);

  // ****************************************************************
  // state declarations
  // ****************************************************************
  logic       en_r, sel_hi_r, sel_lo_r;
  logic       done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r;
  logic       master_enable_bit_r, pha_r, pol_r;
  logic [7:0] rate_r, div_r, txbuf_r, shreg_r, rxbuf_r;
  logic       tx_full_r, rx_full_r, shift_empty_r;
  spm_state_e state_r;
  logic [3:0] half_r;
  logic [2:0] bitcnt_r;
  logic       sck_r, samp_r, outbit_r, sck_d_r, nss_d_r;
  logic [1:0] sel_mode;
  logic       master, slave_sel, slave_on, fault;
  logic       tick, lead, trail, lead_s, trail_s, din;
  logic       load_go, xfer_done, write_collision_flag_ev, ovrn_ev;
  logic [7:0] shin;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign sel_mode = {sel_hi_r, sel_lo_r};
  // R09 master select
  assign master = en_r & master_enable_bit_r;
  // R05 three-wire always selected
  assign slave_sel = (sel_mode == SPM_SEL_3WIRE) |
                     ((sel_mode == SPM_SEL_MULTI) & ~nss_s);
  assign slave_on = en_r & ~master_enable_bit_r & slave_sel;
  // R06 R15 R21 multi-master fault
  assign fault = master & (sel_mode == SPM_SEL_MULTI) & ~nss_s;

  // R19 half period is rate plus one clocks
  assign tick = (state_r == SPM_RUN) & (div_r == rate_r);
  // R04 R18 slave edges only when selected
  assign lead_s  = slave_on & (sck_s != sck_d_r) & (sck_s != pol_r);
  assign trail_s = slave_on & (sck_s != sck_d_r) & (sck_s == pol_r);
  assign lead    = (tick & ~half_r[0]) | lead_s;
  assign trail   = (tick & half_r[0]) | trail_s;
  assign din     = master ? miso_s : mosi_s;
  assign shin    = {shreg_r[6:0], pha_r ? din : samp_r};
  // R20 eighth clock ends transfer
  assign xfer_done = en_r & ~fault & trail & (bitcnt_r == SPM_LAST_BIT);
  // R10 move buffer into empty, unlocked shift register
  assign load_go = en_r & ~fault & tx_full_r & shift_empty_r &
                   (bitcnt_r == 3'h0) & ~lead_s & ~trail_s;
  // R17 write collision
  assign write_collision_flag_ev = wr_dat & tx_full_r;
  assign ovrn_ev = xfer_done & ~master & rx_full_r;

  // ****************************************************************
  // serial_control_reg
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // R14 multi-master default
      {done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r} <= SPM_CTRL_RST[7:4];
      sel_hi_r <= SPM_CTRL_RST[SPM_CTL_SELHI];
      sel_lo_r <= SPM_CTRL_RST[SPM_CTL_SELLO];
      en_r     <= SPM_CTRL_RST[SPM_CTL_EN];
    end else begin
      // R12 done flag, set wins
      done_r <= (wr_ctl ? wd[SPM_CTL_DONE] : done_r) | xfer_done;
      write_collision_flag_r <= (wr_ctl ? wd[SPM_CTL_WRITE_COLLISION_FLAG] : write_collision_flag_r) | write_collision_flag_ev;
      // R15 mode fault flag
      mode_fault_flag_r <= (wr_ctl ? wd[SPM_CTL_MODE_FAULT_FLAG] : mode_fault_flag_r) | fault;
      ovrn_r <= (wr_ctl ? wd[SPM_CTL_OVRN] : ovrn_r) | ovrn_ev;
      if (wr_ctl) begin
        sel_hi_r <= wd[SPM_CTL_SELHI];
        sel_lo_r <= wd[SPM_CTL_SELLO];
      end
      // R15 unit disabled on fault
      if (fault) begin
        en_r <= 1'b0;
      end else if (wr_ctl) begin
        en_r <= wd[SPM_CTL_EN];
      end
    end
  end

  // ****************************************************************
  // serial_config_reg and serial_clock_rate_reg
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_enable_bit_r <= SPM_CFG_RST[SPM_CFG_MASTER_ENABLE_BIT];
      pha_r   <= SPM_CFG_RST[SPM_CFG_PHA];
      pol_r   <= SPM_CFG_RST[SPM_CFG_POL];
      rate_r  <= SPM_RATE_RST;
    end else begin
      // R15 master enable cleared on fault
      if (fault) begin
        master_enable_bit_r <= 1'b0;
      end else if (wr_cfg) begin
        master_enable_bit_r <= wd[SPM_CFG_MASTER_ENABLE_BIT];
      end
      if (wr_cfg) begin
        pha_r <= wd[SPM_CFG_PHA];
        pol_r <= wd[SPM_CFG_POL];
      end
      if (wr_rate) begin
        rate_r <= wd;
      end
    end
  end

  // ****************************************************************
  // transmit buffer
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txbuf_r   <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_dat & ~tx_full_r) begin
      // R10 load transmit buffer
      txbuf_r   <= wd;
      tx_full_r <= 1'b1;
    end else if (load_go) begin
      tx_full_r <= 1'b0;
    end
  end

  // ****************************************************************
  // shift engine
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= SPM_IDLE;
      shreg_r       <= 8'h00;
      shift_empty_r <= 1'b1;
      bitcnt_r      <= 3'h0;
      half_r        <= 4'h0;
      div_r         <= 8'h00;
      sck_r         <= 1'b0;
      samp_r        <= 1'b0;
      outbit_r      <= 1'b0;
      sck_d_r       <= 1'b0;
      nss_d_r       <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      nss_d_r <= nss_s;
      if (!en_r || fault) begin
        // R21 abort on fault or disable
        state_r       <= SPM_IDLE;
        shift_empty_r <= 1'b1;
        bitcnt_r      <= 3'h0;
        sck_r         <= pol_r;
      end else begin
        if (load_go) begin
          // R11 start shifting at once
          shreg_r       <= txbuf_r;
          outbit_r      <= txbuf_r[7];
          shift_empty_r <= 1'b0;
          half_r        <= 4'h0;
          div_r         <= 8'h00;
          sck_r         <= pol_r;
          state_r       <= master ? SPM_RUN : SPM_IDLE;
        end else if (state_r == SPM_RUN) begin
          div_r <= tick ? 8'h00 : div_r + 8'h01;
          if (tick) begin
            half_r <= half_r + 4'h1;
            sck_r  <= ~sck_r;
          end
        end else begin
          sck_r <= pol_r;
        end
        // R18 phase picks sampling edge
        if (lead) begin
          if (pha_r) begin
            outbit_r <= shreg_r[7];
          end else begin
            samp_r <= din;
          end
        end
        // R01 R13 msb first shift
        if (trail) begin
          shreg_r  <= shin;
          bitcnt_r <= bitcnt_r + 3'h1;
          if (!pha_r) begin
            outbit_r <= shreg_r[6];
          end
        end
        // R20 empty after eighth bit
        if (xfer_done) begin
          shift_empty_r <= 1'b1;
          state_r       <= SPM_IDLE;
        end
        if ((sel_mode == SPM_SEL_MULTI) && nss_d_r && !nss_s && !master) begin
          bitcnt_r <= 3'h0;
        end
      end
    end
  end

  // ****************************************************************
  // receive buffer
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxbuf_r   <= 8'h00;
      rx_full_r <= 1'b0;
    end else if (xfer_done && !ovrn_ev) begin
      // R13 copy byte to receive buffer
      rxbuf_r   <= shin;
      rx_full_r <= 1'b1;
    end else if (rd_dat) begin
      rx_full_r <= 1'b0;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rd_mux = 8'h00;
    case (s_axi_araddr)
      SPM_ADDR_CTRL: rd_mux = {done_r, write_collision_flag_r, mode_fault_flag_r, ovrn_r, sel_hi_r,
                               sel_lo_r, ~tx_full_r, en_r};
      SPM_ADDR_CFG:  rd_mux = {(state_r == SPM_RUN) | (bitcnt_r != 3'h0),
                               master_enable_bit_r, pha_r, pol_r, slave_on, nss_s,
                               shift_empty_r, ~rx_full_r};
      SPM_ADDR_DATA: rd_mux = rxbuf_r;
      SPM_ADDR_RATE: rd_mux = rate_r;
      default:       rd_mux = 8'h00;
    endcase
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  // R04 clock driven only by master
  assign sck_out   = master ? sck_r : pol_r;
  assign sck_oe_n  = ~master;
  // R01 master data out
  assign mosi_out  = outbit_r;
  assign mosi_oe_n = ~master;
  // R02 R03 slave output drive
  assign miso_out  = outbit_r;
  assign miso_oe_n = ~slave_on;
  // R07 select driven from lower mode bit
  assign nss_out   = sel_lo_r;
  assign nss_oe_n  = ~sel_hi_r;
  // R08 routed unless three-wire
  assign nss_routed = (sel_mode != SPM_SEL_3WIRE);

endmodule

//--- spm_top_properties.sv
// checker: bus handshake and pin role relations of the serial port unit
`timescale 1ns/1ps
module spm_top_properties (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sck_oe_n,
  input wire logic        mosi_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        nss_in,
  input wire logic        nss_oe_n,
  input wire logic        nss_routed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid
    && s_axi_awready |=> s_axi_bvalid) else $error("write unanswered");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read unanswered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  AST_RDATA_BYTE: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper bits set");
  AST_MOSI_ROLE: assert property (
    !mosi_oe_n |-> !sck_oe_n && miso_oe_n) else $error("master roles");
  AST_MISO_ROLE: assert property (
    !miso_oe_n |-> sck_oe_n && mosi_oe_n) else $error("slave roles");
  AST_NSS_PIN: assert property (
    !nss_oe_n |-> nss_routed) else $error("select driven unrouted");
  AST_MODE_FAULT: assert property (
    !sck_oe_n && !nss_in && nss_oe_n && nss_routed |-> ##[1:6] sck_oe_n)
    else $error("mode fault missed");
endmodule

//--- spm_slave_model.sv
// partner: spi slave device answering a master transfer
`timescale 1ns/1ps
module spm_slave_model #(
  parameter int DLY = 0
) (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] rx_sh = 8'h00;
  logic [7:0] tx_sh = 8'h00;
  logic [2:0] nb    = 3'h0;
  initial begin
    miso = 1'b0;
    got = 8'h00;
  end
  always @(posedge sel) begin
    tx_sh = reply;
    miso = reply[7];
    nb = 3'h0;
  end
  always @(negedge sel) miso = ~miso;
  always @(posedge sck) if (sel) begin
    rx_sh = {rx_sh[6:0], mosi};
    nb = nb + 3'h1;
    if (nb == 3'h0) got = rx_sh;
  end
  always @(negedge sck) if (sel) begin
    tx_sh = (nb == 3'h0) ? reply : {tx_sh[6:0], 1'b0};
    miso <= #(DLY) tx_sh[7];
  end
endmodule

//--- spm_top_tb.sv
// testbench: register rows, master and slave transfers, mode fault
`timescale 1ns/1ps
module spm_top_tb
  import spm_pkg::*;
;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr, wdata, rexp;
    logic [1:0] resp;
    logic [2:0] pins;
  } spm_row_s;
  logic        clock = 1'b0, reset_n = 1'b0, sel = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, got;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, m_miso;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        sck_in = 1'b0, mosi_in = 1'b0, nss_in = 1'b1, miso_in;
  logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out;
  logic        miso_oe_n, nss_out, nss_oe_n, nss_routed;
  int          miscompares = 0, comparisons = 0, edges = 0;
  spm_row_s    rows [9] = '{
    '{1'b0, SPM_ADDR_CTRL, 8'h00, 8'h06, SPM_RESP_OKAY, 3'h7},
    '{1'b0, SPM_ADDR_CFG, 8'h00, 8'h07, SPM_RESP_OKAY, 3'h7},
    '{1'b0, SPM_ADDR_RATE, 8'h00, 8'h00, SPM_RESP_OKAY, 3'h7},
    '{1'b0, 8'h10, 8'h00, 8'h00, SPM_RESP_SLVERR, 3'h7},
    '{1'b1, SPM_ADDR_RATE, 8'h03, 8'h03, SPM_RESP_OKAY, 3'h7},
    '{1'b1, 8'h14, 8'h55, 8'h00, SPM_RESP_SLVERR, 3'h7},
    '{1'b1, SPM_ADDR_CTRL, 8'h0C, 8'h0E, SPM_RESP_OKAY, 3'h5},
    '{1'b1, SPM_ADDR_CTRL, 8'h08, 8'h0A, SPM_RESP_OKAY, 3'h4},
    '{1'b1, SPM_ADDR_CTRL, 8'h00, 8'h02, SPM_RESP_OKAY, 3'h2}};

  always #20 clock = ~clock;
  always @(posedge sck_out) edges++;
  assign miso_in = miso_oe_n ? m_miso : miso_out;

  spm_top DUT (.*);
  spm_slave_model #(.DLY(40)) u_slave (.sck(sck_out), .mosi(mosi_out),
    .sel(sel), .reply(8'h3C), .miso(m_miso), .got(got));

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axw(a, d);
    chk(32'(r), 32'(SPM_RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(v, exp);
  endtask
  task automatic pchk(ref logic s, input logic e, input int n);
    repeat (n) @(posedge clock);
    chk(32'(s), 32'(e));
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      axr(SPM_ADDR_CTRL);
      n++;
    end while (v[SPM_CTL_DONE] !== 1'b1 && n < 100);
    chk(32'(v[SPM_CTL_DONE]), 32'h1);
  endtask
  task automatic slv_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= b[i];
      repeat (4) @(posedge clock);
      sck_in <= 1'b1;
      repeat (4) @(posedge clock);
      sck_in <= 1'b0;
    end
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(rows[i].addr, rows[i].wdata);
        chk(32'(r), 32'(rows[i].resp));
      end
      axr(rows[i].addr);
      chk(v, 32'(rows[i].rexp));
      chk(32'(r), 32'(rows[i].resp));
      chk(32'({nss_routed, nss_oe_n, nss_out}), 32'(rows[i].pins));
    end
    sel <= 1'b1;
    wr(SPM_ADDR_CFG, 8'h40);
    wr(SPM_ADDR_CTRL, 8'h01);
    edges = 0;
    pchk(sck_oe_n, 1'b0, 2);
    pchk(mosi_oe_n, 1'b0, 0);
    wr(SPM_ADDR_DATA, 8'hA5);
    wr(SPM_ADDR_DATA, 8'h5A);
    wr(SPM_ADDR_DATA, 8'h77);
    wait_done();
    chk(32'(v[SPM_CTL_WRITE_COLLISION_FLAG]), 32'h1);
    chk(32'(got), 32'hA5);
    rd(SPM_ADDR_DATA, 32'h3C);
    wr(SPM_ADDR_CTRL, 8'h01);
    wait_done();
    chk(32'(got), 32'h5A);
    rd(SPM_ADDR_DATA, 32'h3C);
    repeat (80) @(posedge clock);
    chk(32'(edges), 32'd16);
    sel <= 1'b0;
    wr(SPM_ADDR_CFG, 8'h70);
    wr(SPM_ADDR_CTRL, 8'h01);
    sel <= 1'b1;
    wr(SPM_ADDR_DATA, 8'h96);
    wait_done();
    chk(32'(got), 32'h96);
    rd(SPM_ADDR_DATA, 32'h3C);
    sel <= 1'b0;
    wr(SPM_ADDR_CFG, 8'h00);
    wr(SPM_ADDR_CTRL, 8'h01);
    pchk(miso_oe_n, 1'b0, 2);
    slv_byte(8'hC3);
    @(posedge clock);
    wait_done();
    rd(SPM_ADDR_DATA, 32'hC3);
    wr(SPM_ADDR_CTRL, 8'h00);
    pchk(miso_oe_n, 1'b1, 2);
    wr(SPM_ADDR_CTRL, 8'h05);
    pchk(miso_oe_n, 1'b1, 2);
    nss_in <= 1'b0;
    pchk(miso_oe_n, 1'b0, 5);
    nss_in <= 1'b1;
    repeat (3) @(posedge clock);
    wr(SPM_ADDR_CFG, 8'h40);
    wr(SPM_ADDR_DATA, 8'h11);
    repeat (10) @(posedge clock);
    nss_in <= 1'b0;
    pchk(sck_oe_n, 1'b1, 6);
    rd(SPM_ADDR_CTRL, 32'h26);
    axr(SPM_ADDR_CFG);
    chk(32'(v[SPM_CFG_MASTER_ENABLE_BIT]), 32'h0);
    nss_in <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(SPM_ADDR_CTRL, 32'h06);
    conclude();
  end
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
bind spm_top spm_top_properties u_props (.*);
